// *** dv/gpa_pins.sv ***
module gpa_pins (
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_o,
  input wire logic [7:0] pin_pullup_o,
  input wire logic [7:0] ext_i,
  output logic [7:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // driven bits echo the pad, pulled inputs read high, others the outside level
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & (pin_pullup_o | ext_i));
endmodule : gpa_pins

// *** dv/gpa_port_bench.sv ***
module gpa_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin n_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, g, x); end end
  typedef struct {logic [1:0] m; logic w; logic [11:0] a; logic [31:0] d, e; logic r;} gpa_row_s;
  logic clk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic pready_o, pslverr_o, pin_reduced_drive_o, er;
  logic [1:0] mode_i = '0;
  logic [7:0] ext_i = 8'h30, bus_out_i = 8'h3C, bus_oe_i = 8'hF0;
  logic [7:0] pin_i, pin_o, pin_oe_o, pin_pullup_o;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  // mode, write, address, write data, read data, error
  gpa_row_s rows[12] = '{'{2'h0, 1'b1, 12'h004, 32'h0F, 32'h0, 1'b0},
    '{2'h0, 1'b1, 12'h000, 32'hA5, 32'h0, 1'b0}, '{2'h0, 1'b0, 12'h000, 32'h0, 32'h35, 1'b0},
    '{2'h0, 1'b1, 12'h008, 32'h1, 32'h0, 1'b0}, '{2'h0, 1'b0, 12'h000, 32'h0, 32'hF5, 1'b0},
    '{2'h1, 1'b0, 12'h000, 32'h0, 32'h0, 1'b1}, '{2'h1, 1'b1, 12'h004, 32'hFF, 32'h0, 1'b1},
    '{2'h1, 1'b0, 12'h010, 32'h0, 32'h1, 1'b0}, '{2'h2, 1'b1, 12'h00C, 32'h1, 32'h0, 1'b1},
    '{2'h0, 1'b0, 12'h004, 32'h0, 32'h0F, 1'b0}, '{2'h0, 1'b0, 12'h014, 32'h0, 32'h0, 1'b1},
    '{2'h0, 1'b0, 12'h008, 32'h0, 32'h1, 1'b0}};
  always #2.5 clk_i = ~clk_i;
  gpa_port u_gpa_port (.*);
  gpa_pins u_gpa_pins (.*);
  // mode settles a cycle before setup, since decode may see a registered copy
  task automatic apb(input logic [1:0] m, input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_i);
    mode_i <= m;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // hang guard, run needs about a hundred cycles
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  // table first, then one-shot drive, expanded pins and a second reset
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK(pin_oe_o, 8'h00)
    foreach (rows[i])
    begin
      apb(rows[i].m, rows[i].w, rows[i].a, rows[i].d);
      `CHK({er, rows[i].w ? 32'h0 : rd}, {rows[i].r, rows[i].e})
    end
    `CHK({pin_oe_o, pin_o & pin_oe_o, pin_pullup_o}, {8'h0F, 8'h05, 8'hF0})
    $display("table done");
    apb(2'h0, 1'b1, 12'h00C, 32'h1);
    apb(2'h0, 1'b1, 12'h00C, 32'h0);
    apb(2'h0, 1'b0, 12'h00C, 32'h0);
    `CHK({rd, pin_reduced_drive_o}, {32'h0000_0101, 1'b1})
    apb(2'h1, 1'b0, 12'h010, 32'h0);
    repeat (3) @(posedge clk_i);
    `CHK({pin_oe_o, pin_o & 8'hF0, pin_pullup_o}, {8'hF0, 8'h30, 8'h00})
    $display("drive and expanded done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    apb(2'h0, 1'b0, 12'h004, 32'h0);
    `CHK({rd, pin_oe_o, pin_reduced_drive_o}, {32'h0000_0000, 8'h00, 1'b0})
    $display("reset done");
    print_verdict();
  end
endmodule : gpa_port_bench

// *** dv/gpa_port_props.sv ***
module gpa_port_props #(parameter int WIDTH = 8) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [1:0] mode_i,
  input wire logic [WIDTH-1:0] bus_out_i,
  input wire logic [WIDTH-1:0] bus_oe_i,
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] pin_o,
  input wire logic [WIDTH-1:0] pin_oe_o,
  input wire logic [WIDTH-1:0] pin_pullup_o,
  input wire logic pin_reduced_drive_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // first access cycle of a transfer
  sequence s_acc;
    psel_i && penable_i && !pready_o;
  endsequence
  // expanded long enough for the pad registers to settle
  sequence s_exp;
    mode_i == 2'b01 ##1 mode_i == 2'b01 ##1 mode_i == 2'b01;
  endsequence
  chk_one_wait: assert property (s_acc |=> pready_o ##1 !pready_o)
    else $error("ready not one cycle after access");
  chk_data_unmap: assert property
    (s_acc ##0 (paddr_i == gpa_pkg::PORT_DATA_OFS && mode_i != 2'b00) |=> pslverr_o)
    else $error("data register answered outside single-chip");
  chk_dir_unmap: assert property
    (s_acc ##0 (paddr_i == gpa_pkg::PORT_DIR_OFS && mode_i != 2'b00) |=> pslverr_o)
    else $error("direction register answered outside single-chip");
  chk_drv_unmap: assert property
    (s_acc ##0 (paddr_i == gpa_pkg::DRIVE_CTRL_OFS && mode_i[1]) |=> pslverr_o)
    else $error("drive control answered in peripheral mode");
  chk_data_mapped: assert property
    (s_acc ##0 (paddr_i == gpa_pkg::PORT_DATA_OFS && mode_i == 2'b00) |=> !pslverr_o)
    else $error("data register refused in single-chip");
  chk_reset_in: assert property ($fell(rst_i) |-> pin_oe_o == '0 && !pin_reduced_drive_o)
    else $error("pins not inputs after reset");
  chk_pull_in: assert property ((pin_pullup_o & pin_oe_o) == '0)
    else $error("pull-up on a driven pin");
  chk_pull_exp: assert property (s_exp |-> pin_pullup_o == '0)
    else $error("pull-up active in expanded mode");
  chk_exp_bus: assert property
    (s_exp |-> pin_oe_o == bus_oe_i && (pin_o & bus_oe_i) == (bus_out_i & bus_oe_i))
    else $error("pins not following the external bus");
endmodule : gpa_port_props

bind gpa_port gpa_port_props #(.WIDTH(WIDTH)) u_gpa_port_props (.*);

// *** pkg/gpa_ctrl_if.sv ***
// port control bundle between the register file and the pad stage
interface gpa_ctrl_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] out_val;
  logic [WIDTH-1:0] dir;
  logic pullup_en;
  logic reduced_drive;
  gpa_pkg::gpa_mode_e mode;
  logic [WIDTH-1:0] bus_out;
  logic [WIDTH-1:0] bus_oe;
  modport regs (output out_val, output dir, output pullup_en, output reduced_drive,
    output mode, output bus_out, output bus_oe);
  modport pads (input out_val, input dir, input pullup_en, input reduced_drive,
    input mode, input bus_out, input bus_oe);
endinterface : gpa_ctrl_if

// *** pkg/gpa_pkg.sv ***
package gpa_pkg;
  // register byte offsets on the apb window
  localparam logic [11:0] PORT_DATA_OFS = 12'h0000;
  localparam logic [11:0] PORT_DIR_OFS = 12'h0004;
  localparam logic [11:0] PULLUP_CTRL_OFS = 12'h0008;
  localparam logic [11:0] DRIVE_CTRL_OFS = 12'h000C;
  localparam logic [11:0] MODE_STAT_OFS = 12'h0010;
  // field positions
  localparam int PULLUP_EN_BIT = 0;
  localparam int REDUCED_DRIVE_BIT = 0;
  localparam int DRIVE_LOCKED_BIT = 8;
  // reset values
  localparam logic [7:0] PORT_DATA_RST = 8'h00;
  localparam logic [7:0] PORT_DIR_RST = 8'h00;
  localparam logic PULLUP_EN_RST = 1'b0;
  localparam logic REDUCED_DRIVE_RST = 1'b0;
  // operating modes
  typedef enum logic [1:0]
  {
    GPA_SINGLE_CHIP = 2'b00,
    GPA_EXPANDED = 2'b01,
    GPA_PERIPHERAL = 2'b10
  } gpa_mode_e;
endpackage : gpa_pkg

// *** verilog/gpa_pad_stage.sv ***
// registered pad drivers: output value, enable, pull-up and drive strength
module gpa_pad_stage #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  gpa_ctrl_if.pads ctl,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_o,
  output logic [WIDTH-1:0] pin_pullup_o,
  output logic pin_reduced_drive_o
);
  logic expanded;

  // expanded mode hands the pins to the external address/data bus
  assign expanded = (ctl.mode == gpa_pkg::GPA_EXPANDED);

  // pad outputs, all flopped; reset leaves every pin an undriven input
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_o <= '0;
      pin_oe_o <= '0;
      pin_pullup_o <= '0;
      pin_reduced_drive_o <= 1'b0;
    end
    else
    begin
      pin_o <= expanded ? ctl.bus_out : ctl.out_val;
      pin_oe_o <= expanded ? ctl.bus_oe : ctl.dir;
      // pull-ups only on inputs and never in expanded mode
      pin_pullup_o <= (expanded || !ctl.pullup_en) ? '0 : ~ctl.dir;
      pin_reduced_drive_o <= ctl.reduced_drive;
    end
  end
endmodule : gpa_pad_stage

// *** verilog/gpa_port.sv ***
// What this block does
// - data register readable and writable any time in single-chip
// - reset makes all pins inputs
// - expanded uses pins for bus, single-chip gpio
// - data register unmapped in expanded/peripheral
// - mapped data register accepts any access
// - direction bit one drives pin out
// - direction register unmapped in expanded/peripheral
// - direction register resets to zero
// - pull-up enable pulls up input pins
// - no pull-ups in expanded mode
// - reduced-drive bit weakens all outputs
// - reduced-drive register written once after reset
// - reduced-drive register unmapped in peripheral
//
// The register offsets and the APB interface to the registers are this design's own decisions.
module gpa_port #(
  parameter int WIDTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // operating mode, held stable by the mode logic
  input wire logic [1:0] mode_i,
  // external bus address/data toward the pins in expanded mode
  input wire logic [WIDTH-1:0] bus_out_i,
  input wire logic [WIDTH-1:0] bus_oe_i,
  // pins
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] pin_o,
  output logic [WIDTH-1:0] pin_oe_o,
  output logic [WIDTH-1:0] pin_pullup_o,
  output logic pin_reduced_drive_o
);
  gpa_ctrl_if #(.WIDTH(WIDTH)) ctl ();

  logic [WIDTH-1:0] port_data;
  logic [WIDTH-1:0] port_direction_reg;
  logic port_pullup_enable;
  logic port_reduced_drive_enable;
  logic drive_locked;
  gpa_pkg::gpa_mode_e mode;
  logic access;
  logic wr_access;
  logic rd_access;
  logic data_mapped;
  logic dir_mapped;
  logic drive_mapped;
  logic hit_data;
  logic hit_dir;
  logic hit_pull;
  logic hit_drive;
  logic hit_mode;
  logic addr_ok;
  logic [31:0] next_rdata;

  // decode one register offset
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] ofs);
    reg_hit = (addr == ofs);
  endfunction : reg_hit

  // unknown mode codes fall back to peripheral, the most restrictive map
  always_comb
  begin
    case (mode_i)
      2'b00: mode = gpa_pkg::GPA_SINGLE_CHIP;
      2'b01: mode = gpa_pkg::GPA_EXPANDED;
      default: mode = gpa_pkg::GPA_PERIPHERAL;
    endcase
  end

  // map visibility per mode
  assign data_mapped = (mode == gpa_pkg::GPA_SINGLE_CHIP);
  assign dir_mapped = (mode == gpa_pkg::GPA_SINGLE_CHIP);
  assign drive_mapped = (mode != gpa_pkg::GPA_PERIPHERAL);

  // access phase with one wait state; pready is registered so it rises one
  // cycle into the access phase, giving every transfer exactly one wait
  assign access = psel_i && penable_i && !pready_o;
  assign wr_access = access && pwrite_i;
  assign rd_access = access && !pwrite_i;

  assign hit_data = reg_hit(paddr_i, gpa_pkg::PORT_DATA_OFS) && data_mapped;
  assign hit_dir = reg_hit(paddr_i, gpa_pkg::PORT_DIR_OFS) && dir_mapped;
  assign hit_pull = reg_hit(paddr_i, gpa_pkg::PULLUP_CTRL_OFS);
  assign hit_drive = reg_hit(paddr_i, gpa_pkg::DRIVE_CTRL_OFS) && drive_mapped;
  assign hit_mode = reg_hit(paddr_i, gpa_pkg::MODE_STAT_OFS);
  assign addr_ok = hit_data || hit_dir || hit_pull || hit_drive || hit_mode;

  // output latch, no access-time restriction while mapped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_data <= gpa_pkg::PORT_DATA_RST;
    else if (wr_access && hit_data)
      port_data <= pwdata_i[WIDTH-1:0];
  end

  // direction register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_direction_reg <= gpa_pkg::PORT_DIR_RST;
    else if (wr_access && hit_dir)
      port_direction_reg <= pwdata_i[WIDTH-1:0];
  end

  // pull-up control, mapped in every mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      port_pullup_enable <= gpa_pkg::PULLUP_EN_RST;
    else if (wr_access && hit_pull)
      port_pullup_enable <= pwdata_i[gpa_pkg::PULLUP_EN_BIT];
  end

  // write-once drive control; an unmapped write does not burn the one shot
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_reduced_drive_enable <= gpa_pkg::REDUCED_DRIVE_RST;
      drive_locked <= 1'b0;
    end
    else if (wr_access && hit_drive && !drive_locked)
    begin
      port_reduced_drive_enable <= pwdata_i[gpa_pkg::REDUCED_DRIVE_BIT];
      drive_locked <= 1'b1;
    end
  end

  // read mux; unmapped registers read zero
  always_comb
  begin
    next_rdata = '0;
    if (hit_data)
      next_rdata[WIDTH-1:0] = (port_direction_reg & port_data) |
        (~port_direction_reg & pin_i);
    else if (hit_dir)
      next_rdata[WIDTH-1:0] = port_direction_reg;
    else if (hit_pull)
      next_rdata[gpa_pkg::PULLUP_EN_BIT] = port_pullup_enable;
    else if (hit_drive)
    begin
      next_rdata[gpa_pkg::REDUCED_DRIVE_BIT] = port_reduced_drive_enable;
      next_rdata[gpa_pkg::DRIVE_LOCKED_BIT] = drive_locked;
    end
    else if (hit_mode)
      next_rdata[1:0] = mode;
  end

  // apb answer: pready and slverr for one cycle, data held until next read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end
    else
    begin
      pready_o <= access;
      pslverr_o <= access && !addr_ok;
      if (rd_access)
        prdata_o <= next_rdata;
    end
  end

  // control bundle to the pad stage
  assign ctl.out_val = port_data;
  assign ctl.dir = port_direction_reg;
  assign ctl.pullup_en = port_pullup_enable;
  assign ctl.reduced_drive = port_reduced_drive_enable;
  assign ctl.mode = mode;
  assign ctl.bus_out = bus_out_i;
  assign ctl.bus_oe = bus_oe_i;

  gpa_pad_stage #(.WIDTH(WIDTH)) u_pads (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ctl(ctl),
    .pin_o(pin_o),
    .pin_oe_o(pin_oe_o),
    .pin_pullup_o(pin_pullup_o),
    .pin_reduced_drive_o(pin_reduced_drive_o)
  );
endmodule : gpa_port
